// [hdl/mmu_first_level_descriptor_check.sv]
// First-level descriptor fetch, decode and section permission check.
// Assumes a same-clock table-walk memory and a plain register port.
`timescale 1ns/100ps
`include "mmu_l1_cfg.svh"

module mmu_first_level_descriptor_check (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_clk_en,
  // Register port
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [31:0]            i_reg_wdata,
  input  wire logic                   i_reg_we,
  input  wire logic                   i_reg_re,
  output logic      [31:0]            o_reg_rdata,
  // Core request
  input  wire logic                   i_req_valid,
  input  wire mmu_l1_pkg::core_req_s  i_req,
  output logic                        o_req_ready,
  // Result
  output logic                        o_done,
  output logic                        o_abort,
  output logic                        o_mem_valid,
  output mmu_l1_pkg::xlate_res_s      o_res,
  // Table walk
  output logic                        o_walk_req,
  output logic      [31:0]            o_walk_addr,
  input  wire logic                   i_walk_ack,
  input  wire logic [31:0]            i_walk_data
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_L1   = 4'h2,
    ST_L2   = 4'h4,
    ST_OUT  = 4'h8
  } walk_state_e;

  walk_state_e            state_q;
  walk_state_e            state_d;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0]            ctrl_q;
  logic [31:0]            table_q;
  logic [31:0]            domain_q;
  logic [31:0]            faddr_q;
  logic [31:0]            rdata_q;
  mmu_l1_pkg::core_req_s  req_q;
  mmu_l1_pkg::xlate_res_s res_q;
  mmu_l1_pkg::xlate_res_s res_d;
  logic [31:0]            l2_addr_q;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [1:0] desc_type(
    input logic [31:0] desc
  );
    desc_type = desc[1:0];
  endfunction : desc_type

  function automatic logic [3:0] desc_domain(
    input logic [31:0] desc
  );
    desc_domain = desc[8:5];
  endfunction : desc_domain

  function automatic logic [1:0] domain_setting(
    input logic [31:0] dac,
    input logic [3:0]  dom
  );
    domain_setting = dac[{dom, 1'b0} +: 2];
  endfunction : domain_setting

  // Permission field check for a section in a client domain
  function automatic logic ap_allows(
    input logic [1:0] ap,
    input logic       sys,
    input logic       rom,
    input logic       user,
    input logic       write
  );
    ap_allows = 1'b0;
    unique case (ap)
      2'h0: begin
        if (sys && rom) begin
          ap_allows = 1'b0;
        end else if (sys) begin
          ap_allows = !user && !write;
        end else if (rom) begin
          ap_allows = !write;
        end else begin
          ap_allows = 1'b0;
        end
      end
      2'h1: begin
        ap_allows = !user;
      end
      2'h2: begin
        ap_allows = !user || !write;
      end
      2'h3: begin
        ap_allows = 1'b1;
      end
    endcase
  endfunction : ap_allows

  // ----------------------------------------
  // Addresses
  // ----------------------------------------
  logic [31:0] l1_addr;
  logic [31:0] l2_addr;

  assign l1_addr = {table_q[31:14], req_q.va[31:20], 2'b00};
  assign l2_addr = {i_walk_data[31:10], req_q.va[19:12], 2'b00};

  // ----------------------------------------
  // Handshake outputs
  // ----------------------------------------
  assign o_req_ready = (state_q == ST_IDLE);
  assign o_walk_req  = (state_q == ST_L1) || (state_q == ST_L2);
  assign o_walk_addr = (state_q == ST_L2) ? l2_addr_q : l1_addr;
  assign o_done      = (state_q == ST_OUT);
  assign o_abort     = o_done
                     && ((res_q.kind == mmu_l1_pkg::XL_FAULT_TRANS)
                     ||  (res_q.kind == mmu_l1_pkg::XL_FAULT_DOMAIN)
                     ||  (res_q.kind == mmu_l1_pkg::XL_FAULT_PERM));
  assign o_mem_valid = o_done
                     && ((res_q.kind == mmu_l1_pkg::XL_FLAT)
                     ||  (res_q.kind == mmu_l1_pkg::XL_SECTION));
  assign o_res       = res_q;
  assign o_reg_rdata = rdata_q;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [1:0] l1_type;

  assign l1_type = desc_type(i_walk_data);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (i_req_valid) begin
          if (ctrl_q[`MMU_CTRL_ENABLE]) begin
            state_d = ST_L1;
          end else begin
            state_d = ST_OUT;
          end
        end
      end
      ST_L1: begin
        if (i_walk_ack) begin
          if (l1_type == `MMU_TYPE_PAGE) begin
            state_d = ST_L2;
          end else begin
            state_d = ST_OUT;
          end
        end
      end
      ST_L2: begin
        if (i_walk_ack) begin
          state_d = ST_OUT;
        end
      end
      ST_OUT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else if (i_clk_en) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Request and second-level address capture
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q <= '0;
    end else if (i_clk_en && (state_q == ST_IDLE) && i_req_valid) begin
      req_q <= i_req;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      l2_addr_q <= 32'h00000000;
    end else if (i_clk_en && (state_q == ST_L1) && i_walk_ack) begin
      l2_addr_q <= l2_addr;
    end
  end

  // ----------------------------------------
  // Descriptor decode and check
  // ----------------------------------------
  logic [3:0] dom;
  logic [1:0] dom_set;
  logic       perm_ok;

  assign dom     = desc_domain(i_walk_data);
  assign dom_set = domain_setting(domain_q, dom);
  assign perm_ok = ap_allows(i_walk_data[11:10],
                             ctrl_q[`MMU_CTRL_SYS],
                             ctrl_q[`MMU_CTRL_ROM],
                             req_q.user,
                             req_q.write);

  always_comb begin
    res_d = res_q;
    unique case (state_q)
      ST_IDLE: begin
        // Translation off passes the address through
        res_d            = '0;
        res_d.pa         = i_req.va;
        res_d.kind       = mmu_l1_pkg::XL_FLAT;
      end
      ST_L1: begin
        res_d.domain     = dom;
        res_d.pa         = 32'h00000000;
        res_d.cacheable  = 1'b0;
        res_d.bufferable = 1'b0;
        unique case (l1_type)
          `MMU_TYPE_INVALID: begin
            res_d.kind = mmu_l1_pkg::XL_FAULT_TRANS;
          end
          `MMU_TYPE_PAGE: begin
            res_d.kind = mmu_l1_pkg::XL_PAGE_TABLE;
          end
          `MMU_TYPE_SECTION: begin
            if (dom_set == `MMU_DOM_MANAGER) begin
              res_d.kind = mmu_l1_pkg::XL_SECTION;
            end else if (dom_set != `MMU_DOM_CLIENT) begin
              res_d.kind = mmu_l1_pkg::XL_FAULT_DOMAIN;
            end else if (perm_ok) begin
              res_d.kind = mmu_l1_pkg::XL_SECTION;
            end else begin
              res_d.kind = mmu_l1_pkg::XL_FAULT_PERM;
            end
            if ((res_d.kind == mmu_l1_pkg::XL_SECTION)) begin
              res_d.pa         = {i_walk_data[31:20], req_q.va[19:0]};
              res_d.cacheable  = i_walk_data[3] && ctrl_q[`MMU_CTRL_CACHE];
              res_d.bufferable = i_walk_data[2] && ctrl_q[`MMU_CTRL_WBUF]
                              && req_q.write;
            end
          end
          `MMU_TYPE_RSVD: begin
            res_d.kind = mmu_l1_pkg::XL_FAULT_TRANS;
          end
        endcase
      end
      ST_L2: begin
        res_d.l2_desc = i_walk_data;
      end
      ST_OUT: begin
        res_d = res_q;
      end
      default: begin
        res_d = res_q;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      res_q <= '0;
    end else if (i_clk_en) begin
      if ((state_q == ST_IDLE) && i_req_valid) begin
        res_q <= res_d;
      end else if (((state_q == ST_L1) || (state_q == ST_L2)) && i_walk_ack) begin
        res_q <= res_d;
      end
    end
  end

  // ----------------------------------------
  // Fault address capture
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      faddr_q <= 32'h00000000;
    end else if (i_clk_en && o_abort) begin
      faddr_q <= req_q.va;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `MMU_CTRL_RST;
    end else if (i_clk_en && i_reg_we && (i_reg_addr == `MMU_OFS_CTRL)) begin
      ctrl_q <= i_reg_wdata & `MMU_CTRL_MASK;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      table_q <= `MMU_TABLE_RST;
    end else if (i_clk_en && i_reg_we && (i_reg_addr == `MMU_OFS_TABLE)) begin
      table_q <= i_reg_wdata & `MMU_TABLE_MASK;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      domain_q <= `MMU_DOMAIN_RST;
    end else if (i_clk_en && i_reg_we && (i_reg_addr == `MMU_OFS_DOMAIN)) begin
      domain_q <= i_reg_wdata;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  logic [31:0] status_word;

  assign status_word = {20'h00000, state_q, res_q.domain,
                        1'b0, res_q.kind};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h00000000;
    end else if (i_clk_en) begin
      if (i_reg_re) begin
        unique case (i_reg_addr)
          `MMU_OFS_CTRL: begin
            rdata_q <= ctrl_q;
          end
          `MMU_OFS_TABLE: begin
            rdata_q <= table_q;
          end
          `MMU_OFS_DOMAIN: begin
            rdata_q <= domain_q;
          end
          `MMU_OFS_STATUS: begin
            rdata_q <= status_word;
          end
          `MMU_OFS_FADDR: begin
            rdata_q <= faddr_q;
          end
          default: begin
            rdata_q <= 32'h00000000;
          end
        endcase
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

endmodule : mmu_first_level_descriptor_check

// [hdl/mmu_l1_cfg.svh]
// Constants for the first-level descriptor check block.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef MMU_L1_CFG_SVH
`define MMU_L1_CFG_SVH

// Register offsets
`define MMU_OFS_CTRL     8'h00
`define MMU_OFS_TABLE    8'h04
`define MMU_OFS_DOMAIN   8'h08
`define MMU_OFS_STATUS   8'h0c
`define MMU_OFS_FADDR    8'h10

// Control bits
`define MMU_CTRL_ENABLE  0
`define MMU_CTRL_CACHE   2
`define MMU_CTRL_WBUF    3
`define MMU_CTRL_SYS     8
`define MMU_CTRL_ROM     9
`define MMU_CTRL_MASK    32'h0000030d
`define MMU_CTRL_RST     32'h00000000
`define MMU_TABLE_MASK   32'hffffc000
`define MMU_TABLE_RST    32'h00000000
`define MMU_DOMAIN_RST   32'h00000000

// Descriptor types
`define MMU_TYPE_INVALID 2'h0
`define MMU_TYPE_PAGE    2'h1
`define MMU_TYPE_SECTION 2'h2
`define MMU_TYPE_RSVD    2'h3

// Domain settings
`define MMU_DOM_CLIENT   2'h1
`define MMU_DOM_MANAGER  2'h3

`endif

// [hdl/mmu_l1_pkg.sv]
// Types for the first-level descriptor check block.
// Assumes the constants header sits beside it.
package mmu_l1_pkg;

  // ----------------------------------------
  // Core request and translation result
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] va;
    logic        write;
    logic        user;
  } core_req_s;

  typedef enum logic [2:0] {
    XL_FLAT         = 3'h0,
    XL_SECTION      = 3'h1,
    XL_PAGE_TABLE   = 3'h2,
    XL_FAULT_TRANS  = 3'h3,
    XL_FAULT_DOMAIN = 3'h4,
    XL_FAULT_PERM   = 3'h5
  } xlate_kind_e;

  typedef struct packed {
    logic [31:0] pa;
    xlate_kind_e kind;
    logic [3:0]  domain;
    logic        cacheable;
    logic        bufferable;
    logic [31:0] l2_desc;
  } xlate_res_s;

endpackage : mmu_l1_pkg

// [bench/mmu_l1_monitor.sv]
// Checker for the first-level descriptor check block.
// Assumes one clock domain and binding to the top module's ports.
`timescale 1ns/100ps
module mmu_l1_monitor (
  input wire logic                  i_core_clk,
  input wire logic                  i_rst,
  input wire logic                  i_clk_en,
  input wire logic                  i_req_valid,
  input wire mmu_l1_pkg::core_req_s i_req,
  input wire logic                  o_req_ready,
  input wire logic                  o_done,
  input wire logic                  o_abort,
  input wire logic                  o_mem_valid,
  input wire mmu_l1_pkg::xlate_res_s o_res,
  input wire logic                  o_walk_req,
  input wire logic [31:0]           o_walk_addr,
  input wire logic                  i_walk_ack,
  input wire logic [31:0]           i_walk_data
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic        l1_pend_q;
  logic [31:0] va_q;
  logic [31:0] desc_q;
  logic        l1_ack;
  assign l1_ack = i_walk_ack && l1_pend_q;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      l1_pend_q <= 1'b0;
      va_q      <= 32'h0;
    end else if (i_clk_en && i_req_valid && o_req_ready) begin
      l1_pend_q <= 1'b1;
      va_q      <= i_req.va;
    end else if (i_walk_ack) begin
      l1_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      desc_q <= 32'h0;
    end else if (i_walk_ack) begin
      desc_q <= i_walk_data;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_trans_fault: assert property (
    l1_ack && i_walk_data[1:0] inside {2'h0, 2'h3} |=> o_done && o_abort
      && o_res.kind == mmu_l1_pkg::XL_FAULT_TRANS) else $error("bad type not a translation fault");
  chk_page_fetch: assert property (
    l1_ack && i_walk_data[1:0] == 2'h1 |=> o_walk_req
      && o_walk_addr == {desc_q[31:10], va_q[19:12], 2'b00}) else $error("second fetch address wrong");
  chk_page_result: assert property (
    i_walk_ack && !l1_pend_q && o_walk_req |=> o_done
      && o_res.kind == mmu_l1_pkg::XL_PAGE_TABLE && o_res.l2_desc == desc_q) else $error("page result wrong");
  chk_section_done: assert property (
    l1_ack && i_walk_data[1:0] == 2'h2 |=> o_done && !o_walk_req
      && o_res.domain == desc_q[8:5]) else $error("section not finished at once");
  chk_section_pa: assert property (
    o_done && o_res.kind == mmu_l1_pkg::XL_SECTION |-> o_res.pa == {desc_q[31:20], va_q[19:0]})
    else $error("section address wrong");
  chk_fault_no_mem: assert property (
    o_done && o_res.kind inside {3'h3, 3'h4, 3'h5} |-> o_abort && !o_mem_valid)
    else $error("faulting access let out");
  chk_pulse_pair: assert property (
    o_abort || o_mem_valid |-> o_done && !(o_abort && o_mem_valid)) else $error("abort and access mixed");
  chk_l1_addr: assert property (
    o_walk_req && l1_pend_q |-> o_walk_addr[13:2] == va_q[31:20] && o_walk_addr[1:0] == 2'b00)
    else $error("descriptor address wrong");
  chk_walk_hold: assert property (
    o_walk_req && !i_walk_ack |=> o_walk_req && $stable(o_walk_addr)) else $error("walk request dropped");
  chk_walk_busy: assert property (
    o_walk_req |-> !o_req_ready && !o_done) else $error("result or ready during walk");

  cover property (l1_ack && i_walk_data[1:0] == 2'h1);
  cover property (o_done && o_res.kind == mmu_l1_pkg::XL_FAULT_PERM);
  cover property (o_done && o_res.kind == mmu_l1_pkg::XL_FAULT_DOMAIN);
  cover property (o_done && o_res.kind == mmu_l1_pkg::XL_SECTION);
endmodule : mmu_l1_monitor

bind mmu_first_level_descriptor_check mmu_l1_monitor u_mon (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_abort(o_abort), .o_mem_valid(o_mem_valid), .o_res(o_res),
  .o_walk_req(o_walk_req), .o_walk_addr(o_walk_addr), .i_walk_ack(i_walk_ack), .i_walk_data(i_walk_data));

// [bench/table_walk_mem.sv]
// Table-walk memory model answering descriptor reads.
// Assumes the same clock as the block; words are loaded by the bench.
`timescale 1ns/100ps
module table_walk_mem (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_walk_req,
  input  wire logic [31:0] i_walk_addr,
  input  wire logic [3:0]  i_delay,
  output logic             o_walk_ack,
  output logic [31:0]      o_walk_data
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0]  wait_q;

  task automatic load(input logic [31:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask : load

  // ----------------------------------------
  // Answer after a programmable wait
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_walk_ack  <= 1'b0;
      o_walk_data <= 32'h0;
      wait_q      <= 4'h0;
    end else begin
      o_walk_ack  <= 1'b0;
      o_walk_data <= ~o_walk_data;
      if (i_walk_req && !o_walk_ack) begin
        if (wait_q >= i_delay) begin
          o_walk_ack  <= 1'b1;
          o_walk_data <= mem.exists(i_walk_addr) ? mem[i_walk_addr] : 32'h0;
          wait_q      <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : table_walk_mem

// [bench/mmu_first_level_descriptor_check_tb_top.sv]
// Testbench for the first-level descriptor check block.
// Assumes the checker and the table-walk model are compiled first.
`timescale 1ns/100ps
`include "mmu_l1_cfg.svh"
module mmu_first_level_descriptor_check_tb_top;
  logic                   i_core_clk = 0, i_rst = 1, clk_en = 1, we = 0, re = 0, req_valid = 0;
  logic                   ready, done, abort, mem_valid, walk_req, walk_ack;
  logic [7:0]             addr = 0;
  logic [31:0]            wdata = 0, rdata, walk_addr, walk_data;
  logic [3:0]             delay = 0;
  mmu_l1_pkg::core_req_s  req = '0;
  mmu_l1_pkg::xlate_res_s res;
  int                     failures = 0, compares = 0;
  localparam logic [31:0] TBASE = 32'h0004_0000;

  initial forever #5 i_core_clk = ~i_core_clk;

  mmu_first_level_descriptor_check DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(clk_en),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rdata),
    .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready), .o_done(done), .o_abort(abort),
    .o_mem_valid(mem_valid), .o_res(res), .o_walk_req(walk_req), .o_walk_addr(walk_addr),
    .i_walk_ack(walk_ack), .i_walk_data(walk_data));
  table_walk_mem walk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_walk_req(walk_req),
    .i_walk_addr(walk_addr), .i_delay(delay), .o_walk_ack(walk_ack), .o_walk_data(walk_data));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk); addr <= a; wdata <= d; we <= 1'b1;
    @(posedge i_core_clk); we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_core_clk); addr <= a; re <= 1'b1;
    @(posedge i_core_clk); re <= 1'b0;
    #1 check(rdata, e, "register read");
  endtask : reg_rd

  // Section descriptor with bit 4 set and 19:12 clear
  function automatic logic [31:0] sec(input logic [11:0] hi, input logic [1:0] ap, input logic [3:0] dom,
                                      input logic [1:0] cb);
    sec = {hi, 8'h00, ap, 1'b0, dom, 1'b1, cb, 2'b10};
  endfunction : sec

  function automatic logic perm_ok(input logic [1:0] ap, input logic s, r, u, w);
    case (ap)
      2'h0: perm_ok = (s && !r) ? (!u && !w) : ((!s && r) ? !w : 1'b0);
      2'h1: perm_ok = !u;
      2'h2: perm_ok = !(u && w);
      default: perm_ok = 1'b1;
    endcase
  endfunction : perm_ok

  task automatic xlate(input logic [31:0] va, input logic w, u, input logic [31:0] l1);
    int n;
    walk.load({TBASE[31:14], va[31:20], 2'b00}, l1);
    @(posedge i_core_clk); req <= '{va: va, write: w, user: u}; req_valid <= 1'b1;
    @(posedge i_core_clk); req_valid <= 1'b0;
    #1 n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge i_core_clk); #1 n++;
    end
    check(n < 40, 1, "no result");
  endtask : xlate

  task automatic xcheck(input mmu_l1_pkg::xlate_kind_e k, input logic [31:0] pa);
    logic f;
    f = k inside {mmu_l1_pkg::XL_FAULT_TRANS, mmu_l1_pkg::XL_FAULT_DOMAIN, mmu_l1_pkg::XL_FAULT_PERM};
    check(res.kind, k, "kind");
    check(abort, f, "abort");
    check(mem_valid, !f && k != mmu_l1_pkg::XL_PAGE_TABLE, "access out");
    if (k inside {mmu_l1_pkg::XL_FLAT, mmu_l1_pkg::XL_SECTION}) check(res.pa, pa, "address");
  endtask : xcheck

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_regs_flat;
    reg_rd(`MMU_OFS_CTRL, 32'h0);
    reg_wr(`MMU_OFS_CTRL, 32'hffff_ffff);
    reg_rd(`MMU_OFS_CTRL, 32'h0000_030d);
    reg_wr(`MMU_OFS_TABLE, 32'hffff_ffff);
    reg_rd(`MMU_OFS_TABLE, 32'hffff_c000);
    reg_wr(8'h40, 32'h1234_5678);
    reg_rd(8'h40, 32'h0);
    reg_wr(`MMU_OFS_CTRL, 32'h0);
    xlate(32'hdead_beef, 1'b1, 1'b1, 32'h0);
    xcheck(mmu_l1_pkg::XL_FLAT, 32'hdead_beef);
  endtask : sc_regs_flat

  task automatic sc_types;
    logic [31:0] va, d;
    reg_wr(`MMU_OFS_TABLE, TBASE);
    reg_wr(`MMU_OFS_DOMAIN, 32'hffff_ffff);
    reg_wr(`MMU_OFS_CTRL, 32'h0000_0001);
    for (int t = 0; t < 4; t++) begin
      va = 32'h1230_0456 + (t << 20);
      d = sec(12'habc, 2'h0, 4'h2, 2'h0);
      d[1:0] = t[1:0];
      if (t == 1) d = {22'h000100, 1'b0, 4'h2, 1'b1, 4'h1};
      walk.load({22'h000100, va[19:12], 2'b00}, 32'h5a5a_0002);
      xlate(va, 1'b0, 1'b0, d);
      if (t == 2) xcheck(mmu_l1_pkg::XL_SECTION, {12'habc, va[19:0]});
      else if (t == 1) begin
        xcheck(mmu_l1_pkg::XL_PAGE_TABLE, 32'h0);
        check(res.l2_desc, 32'h5a5a_0002, "second word");
      end else xcheck(mmu_l1_pkg::XL_FAULT_TRANS, 32'h0);
      if (t[0] != t[1]) check(res.domain, 4'h2, "domain");
    end
  endtask : sc_types

  task automatic sc_perm;
    logic [5:0]  i;
    logic [31:0] va;
    reg_wr(`MMU_OFS_DOMAIN, 32'h5555_5555);
    for (int n = 0; n < 128; n++) begin
      i = n[5:0];
      va = {6'h0c, i, 20'h12345};
      reg_wr(`MMU_OFS_CTRL, {22'h0, i[4], i[5], 4'h0, !n[6], !n[6], 2'b01});
      xlate(va, i[0], i[1], sec({6'h20, i}, i[3:2], 4'h7, i[3:2]));
      if (perm_ok(i[3:2], i[5], i[4], i[1], i[0])) begin
        xcheck(mmu_l1_pkg::XL_SECTION, {6'h20, i, va[19:0]});
        check(res.cacheable, i[3] && !n[6], "cacheable");
        check(res.bufferable, i[2] && i[0] && !n[6], "bufferable");
      end else xcheck(mmu_l1_pkg::XL_FAULT_PERM, 32'h0);
    end
  endtask : sc_perm

  task automatic sc_domain;
    delay <= 4'h3;
    reg_wr(`MMU_OFS_DOMAIN, 32'h0000_2000);
    for (int k = 5; k < 7; k++) begin
      xlate(32'h7650_0010 + (k << 20), 1'b0, 1'b0, sec(12'h111, 2'h3, k[3:0], 2'h0));
      xcheck(mmu_l1_pkg::XL_FAULT_DOMAIN, 32'h0);
      check(res.domain, k, "domain");
      reg_rd(`MMU_OFS_FADDR, 32'h7650_0010 + (k << 20));
    end
  endtask : sc_domain

  initial begin
    #500_000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    sc_regs_flat();
    sc_types();
    sc_perm();
    sc_domain();
    stop_test();
  end
endmodule : mmu_first_level_descriptor_check_tb_top
